// *** common/cko_pkg.sv ***
// cko_pkg: frame offsets, protocol codes and states of the checksum offload
// assumes frames start at the ethernet destination address, no fcs attached
package cko_pkg;
	// ----------------------------------------------------------------
	// frame layout, byte offsets from the first ethernet byte
	// ----------------------------------------------------------------
	localparam logic [15:0] ETYPE_OFS    = 16'h000C; // ethertype high byte
	localparam logic [15:0] ETYPE_IPV4   = 16'h0800;
	localparam logic [15:0] ETYPE_IPV6   = 16'h86DD;
	localparam logic [15:0] IP_OFS       = 16'h000E; // first ip header byte
	localparam logic [15:0] V4_TLEN_OFS  = 16'h0010; // total length
	localparam logic [15:0] V4_PROTO_OFS = 16'h0017; // protocol
	localparam logic [15:0] V4_HCS_OFS   = 16'h0018; // header checksum
	localparam logic [15:0] V4_ADDR_OFS  = 16'h001A; // source address
	localparam logic [15:0] V4_ADDR_END  = 16'h0022; // past dest address
	localparam logic [15:0] V6_PLEN_OFS  = 16'h0012; // payload length
	localparam logic [15:0] V6_NH_OFS    = 16'h0014; // next header
	localparam logic [15:0] V6_ADDR_OFS  = 16'h0016; // source address
	localparam logic [15:0] V6_ADDR_END  = 16'h0036; // past dest address
	localparam logic [15:0] V6_BASE_LEN  = 16'h0028; // fixed base header
	localparam logic [15:0] EXT_FIXED    = 16'h0008; // added to every ext
	localparam int          AH_UNIT_SH   = 2;        // ah length unit 4
	localparam int          EXT_UNIT_SH  = 3;        // other ext unit 8
	localparam logic [15:0] MIN_FRAME    = 16'h003C; // padded frame size

	// ----------------------------------------------------------------
	// protocol and next-header codes
	// ----------------------------------------------------------------
	localparam logic [7:0] NH_HOPOPT = 8'h00;
	localparam logic [7:0] NH_ROUTE  = 8'h2B;
	localparam logic [7:0] NH_FRAG   = 8'h2C;
	localparam logic [7:0] NH_DSTOPT = 8'h3C;
	localparam logic [7:0] NH_AUTH   = 8'h33;
	localparam logic [7:0] NH_TCP    = 8'h06;
	localparam logic [7:0] NH_UDP    = 8'h11;
	localparam logic [7:0] NH_ICMP   = 8'h01;
	localparam logic [7:0] NH_ICMP6  = 8'h3A;
	localparam logic [7:0] NH_NONE   = 8'hFF; // reserved, marks unknown

	// checksum field offset inside the transport header
	localparam logic [15:0] CS_TCP  = 16'h0010;
	localparam logic [15:0] CS_UDP  = 16'h0006;
	localparam logic [15:0] CS_ICMP = 16'h0002;

	// frame engine states
	typedef enum logic [1:0] {
		ST_RUN  = 2'b00,
		ST_FOLD = 2'b01,
		ST_EMIT = 2'b11
	} cko_state_t;
endpackage

// *** core/cko_offload.sv ***
// cko_offload: ip checksum offload engine with its byte fifo
// assumes one clock, byte stream with last flag, frames begin at ethernet
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// small fifo, flip-flop storage
// ----------------------------------------------------------------
module cko_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	input  wire logic             clk_sys, // system clock
	input  wire logic             rst,     // sync reset
	input  wire logic [WIDTH-1:0] s_data,  // write data
	input  wire logic             s_valid, // write request
	output logic                  s_ready, // room left
	output logic      [WIDTH-1:0] m_data,  // head word
	output logic                  m_valid, // not empty
	input  wire logic             m_ready  // head taken
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_r;
	logic [AW-1:0]    rd_r;
	logic [AW:0]      cnt_r;
	logic             push;
	logic             pop;

	// honest flags from the fill count
	assign s_ready = (cnt_r != (AW+1)'(DEPTH));
	assign m_valid = (cnt_r != '0);
	assign m_data  = mem_r[rd_r];
	assign push    = s_valid & s_ready;
	assign pop     = m_valid & m_ready;

	// storage write
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_r[wr_r] <= s_data;
		end
	end

	// pointers and fill count
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wr_r  <= '0;
			rd_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
			end
			if (pop) begin
				rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
			end
			if (push & ~pop) begin
				cnt_r <= cnt_r + 1'b1;
			end else if (pop & ~push) begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end
endmodule

// ----------------------------------------------------------------
// offload engine
// ----------------------------------------------------------------
module cko_offload
	import cko_pkg::*;
#(
	parameter int FIFO_DEPTH = 4
) (
	input  wire logic       clk_sys,         // 125 MHz system clock
	input  wire logic       rst,             // sync reset, active high
	input  wire logic [7:0] in_data,         // frame byte in
	input  wire logic       in_valid,        // byte offered
	input  wire logic       in_last,         // last byte of frame
	output logic            in_ready,        // byte accepted
	input  wire logic       ctl_rx,          // frame is a received one
	input  wire logic       ctl_hdr_en,      // insert ipv4 header sum
	input  wire logic       ctl_pay_en,      // insert transport sum
	output logic      [7:0] out_data,        // frame byte out
	output logic            out_valid,       // byte offered
	output logic            out_last,        // last byte of frame
	input  wire logic       out_ready,       // byte taken
	output logic            patch_valid,     // write checksum pulse
	output logic     [15:0] patch_offset,    // byte offset of field
	output logic     [15:0] patch_value,     // value, high byte first
	output logic            rx_stat_valid,   // status word pulse
	output logic            rx_stat_checked, // transport was checked
	output logic            rx_stat_pay_err  // payload checksum error
);
	// ----------------------------------------------------------------
	// byte path through the fifo
	// ----------------------------------------------------------------
	cko_state_t  state_r;
	logic [8:0]  fifo_q;
	logic        fifo_valid;
	logic        run;
	logic        take;
	logic [7:0]  b;

	// output stalls while a frame result is being settled
	assign run       = (state_r == ST_RUN);
	assign out_valid = fifo_valid & run;
	assign out_data  = fifo_q[7:0];
	assign out_last  = fifo_q[8];
	assign take      = out_valid & out_ready;
	assign b         = fifo_q[7:0];

	cko_fifo #(
		.WIDTH (9),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_sys (clk_sys),
		.rst     (rst),
		.s_data  ({in_last, in_data}),
		.s_valid (in_valid),
		.s_ready (in_ready),
		.m_data  (fifo_q),
		.m_valid (fifo_valid),
		.m_ready (out_ready & run)
	);

	// ones complement fold of a wide sum to 16 bits
	function automatic logic [15:0] fold16(input logic [31:0] a);
		logic [16:0] s;
		logic [16:0] t;
		s = {1'b0, a[15:0]} + {1'b0, a[31:16]};
		t = {1'b0, s[15:0]} + {16'h0000, s[16]};
		return t[15:0];
	endfunction

	// ----------------------------------------------------------------
	// frame sequencing
	// ----------------------------------------------------------------
	logic clr;
	assign clr = rst | (state_r == ST_EMIT);

	// run bytes, then fold, then emit results
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_r <= ST_RUN;
		end else begin
			unique case (state_r)
				ST_RUN:  state_r <= (take & out_last) ? ST_FOLD : ST_RUN;
				ST_FOLD: state_r <= ST_EMIT;
				ST_EMIT: state_r <= ST_RUN;
				default: state_r <= ST_RUN;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// header parsing
	// ----------------------------------------------------------------
	logic [15:0] pos_r;    // index of next byte, count at frame end
	logic        rx_r;
	logic        hdr_en_r;
	logic        pay_en_r;
	logic [7:0]  hi_r;     // high byte of a 16-bit field
	logic        v4_r;
	logic        v6_r;
	logic [15:0] nxt_at_r; // start of the next header
	logic [15:0] ip_end_r; // end of the ip datagram
	logic [7:0]  nh_r;     // type of the header at nxt_at_r
	logic [7:0]  nh_tmp_r;
	logic        ah_r;     // authentication header was seen
	logic        is_ext;
	logic        l4_ok;
	logic [15:0] cs_ofs;
	logic [15:0] cs_at;
	logic        pay_sup;
	logic        pseudo;

	assign is_ext = v6_r & ((nh_r == NH_HOPOPT) | (nh_r == NH_ROUTE) |
		(nh_r == NH_FRAG) | (nh_r == NH_DSTOPT) | (nh_r == NH_AUTH));
	assign l4_ok  = (v4_r | v6_r) & ~is_ext;

	// transport kind decides field place and pseudo-header
	always_comb begin
		cs_ofs  = CS_ICMP;
		pay_sup = 1'b0;
		pseudo  = 1'b0;
		if (l4_ok) begin
			if (nh_r == NH_TCP) begin
				cs_ofs  = CS_TCP;
				pay_sup = 1'b1;
				pseudo  = 1'b1;
			end else if (nh_r == NH_UDP) begin
				cs_ofs  = CS_UDP;
				pay_sup = 1'b1;
				pseudo  = 1'b1;
			end else if ((nh_r == NH_ICMP) & v4_r) begin
				pay_sup = 1'b1;
			end else if ((nh_r == NH_ICMP6) & v6_r) begin
				pay_sup = 1'b1;
				pseudo  = 1'b1;
			end
		end
	end
	assign cs_at = nxt_at_r + cs_ofs;

	// per-frame controls caught with the first byte
	always_ff @(posedge clk_sys) begin
		if (clr) begin
			pos_r    <= '0;
			rx_r     <= 1'b0;
			hdr_en_r <= 1'b0;
			pay_en_r <= 1'b0;
		end else if (take) begin
			pos_r <= pos_r + 16'h0001;
			if (pos_r == '0) begin
				rx_r     <= ctl_rx;
				hdr_en_r <= ctl_hdr_en;
				pay_en_r <= ctl_pay_en;
			end
		end
	end

	// ethertype, lengths and extension header walk
	always_ff @(posedge clk_sys) begin
		if (clr) begin
			hi_r     <= '0;
			v4_r     <= 1'b0;
			v6_r     <= 1'b0;
			nxt_at_r <= '0;
			ip_end_r <= '0;
			nh_r     <= NH_NONE;
			nh_tmp_r <= NH_NONE;
			ah_r     <= 1'b0;
		end else if (take) begin
			hi_r <= b;
			if (pos_r == ETYPE_OFS + 16'h0001) begin
				v4_r <= ({hi_r, b} == ETYPE_IPV4);
				v6_r <= ({hi_r, b} == ETYPE_IPV6);
				nxt_at_r <= IP_OFS + V6_BASE_LEN;
			end
			if (v4_r & (pos_r == IP_OFS)) begin
				nxt_at_r <= IP_OFS + {10'h000, b[3:0], 2'b00};
			end
			if (v4_r & (pos_r == V4_TLEN_OFS + 16'h0001)) begin
				ip_end_r <= IP_OFS + {hi_r, b};
			end
			if (v6_r & (pos_r == V6_PLEN_OFS + 16'h0001)) begin
				ip_end_r <= IP_OFS + V6_BASE_LEN + {hi_r, b};
			end
			if ((v4_r & (pos_r == V4_PROTO_OFS)) |
				(v6_r & (pos_r == V6_NH_OFS))) begin
				nh_r <= b;
			end
			if (is_ext & (pos_r == nxt_at_r)) begin
				nh_tmp_r <= b;
			end
			if (is_ext & (pos_r == nxt_at_r + 16'h0001)) begin
				nh_r <= nh_tmp_r;
				if (nh_r == NH_AUTH) begin
					ah_r     <= 1'b1;
					nxt_at_r <= nxt_at_r + EXT_FIXED +
						(16'(b) << AH_UNIT_SH);
				end else begin
					nxt_at_r <= nxt_at_r + EXT_FIXED +
						(16'(b) << EXT_UNIT_SH);
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// running sums
	// ----------------------------------------------------------------
	logic [31:0] sum_r;  // transport bytes
	logic [31:0] psum_r; // addresses for the pseudo-header
	logic [31:0] hsum_r; // ipv4 header
	logic [31:0] word;
	logic        in_l4;
	logic        in_fld;
	logic        in_addr;
	logic        in_hdr;

	// even offsets are the high byte of a word
	assign word    = pos_r[0] ? {24'h000000, b} : {16'h0000, b, 8'h00};
	assign in_l4   = l4_ok & (pos_r >= nxt_at_r) & (pos_r < ip_end_r);
	assign in_fld  = (pos_r == cs_at) | (pos_r == cs_at + 16'h0001);
	assign in_addr = (v4_r & (pos_r >= V4_ADDR_OFS) &
		(pos_r < V4_ADDR_END)) | (v6_r & (pos_r >= V6_ADDR_OFS) &
		(pos_r < V6_ADDR_END));
	assign in_hdr  = v4_r & ((pos_r == IP_OFS) |
		((pos_r > IP_OFS) & (pos_r < nxt_at_r))) &
		(pos_r != V4_HCS_OFS) & (pos_r != V4_HCS_OFS + 16'h0001);

	// field counts as zero when sending, as itself when checking
	always_ff @(posedge clk_sys) begin
		if (clr) begin
			sum_r  <= '0;
			psum_r <= '0;
			hsum_r <= '0;
		end else if (take) begin
			if (in_l4 & (rx_r | ~in_fld)) begin
				sum_r <= sum_r + word;
			end
			if (in_addr) begin
				psum_r <= psum_r + word;
			end
			if (in_hdr) begin
				hsum_r <= hsum_r + word;
			end
		end
	end

	// ----------------------------------------------------------------
	// results
	// ----------------------------------------------------------------
	logic [15:0] l4_len;
	logic [31:0] ph;
	logic [15:0] pay_sum;
	logic [15:0] pay_val;
	logic        short;
	logic        long;
	logic        len_bad;

	assign l4_len  = ip_end_r - nxt_at_r;
	assign ph      = pseudo ? (psum_r + {24'h000000, nh_r} +
		{16'h0000, l4_len}) : 32'h00000000;
	assign pay_sum = fold16(sum_r + ph);
	// udp sends all ones for a zero result
	assign pay_val = ((~pay_sum == 16'h0000) & (nh_r == NH_UDP)) ?
		16'hFFFF : ~pay_sum;
	// frame ended before the declared datagram end
	assign short   = (pos_r < ip_end_r) | (nxt_at_r > ip_end_r);
	// extra bytes that cannot be ethernet padding
	assign long    = (pos_r > ip_end_r) & (pos_r > MIN_FRAME);
	assign len_bad = short | long;

	// header patch after fold, payload patch and status after emit
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			patch_valid     <= 1'b0;
			patch_offset    <= '0;
			patch_value     <= '0;
			rx_stat_valid   <= 1'b0;
			rx_stat_checked <= 1'b0;
			rx_stat_pay_err <= 1'b0;
		end else begin
			patch_valid   <= 1'b0;
			rx_stat_valid <= 1'b0;
			if ((state_r == ST_FOLD) & ~rx_r & hdr_en_r & v4_r &
				(pos_r >= nxt_at_r)) begin
				patch_valid  <= 1'b1;
				patch_offset <= V4_HCS_OFS;
				patch_value  <= ~fold16(hsum_r);
			end
			if ((state_r == ST_EMIT) & ~rx_r & pay_en_r & pay_sup &
				~ah_r & (pos_r >= cs_at + 16'h0002)) begin
				patch_valid  <= 1'b1;
				patch_offset <= cs_at;
				patch_value  <= pay_val;
			end
			if ((state_r == ST_EMIT) & rx_r) begin
				rx_stat_valid   <= 1'b1;
				rx_stat_checked <= pay_sup;
				rx_stat_pay_err <= pay_sup &
					(len_bad | (pay_sum != 16'hFFFF));
			end
		end
	end
endmodule

`default_nettype wire

// *** sim/cko_offload_properties.sv ***
// cko_offload_properties: port timing checks of the offload engine
// assumes it is bound into every cko_offload instance
`timescale 1ns/100ps
`default_nettype none
module cko_props
	import cko_pkg::*;
(
	input wire logic        clk_sys,        // clock
	input wire logic        rst,            // sync reset
	input wire logic        in_ready,       // fifo room
	input wire logic  [7:0] out_data,       // byte out
	input wire logic        out_valid,      // byte offered
	input wire logic        out_last,       // frame end
	input wire logic        out_ready,      // byte taken
	input wire logic        patch_valid,    // patch pulse
	input wire logic [15:0] patch_offset,   // patch place
	input wire logic [15:0] patch_value,    // patch word
	input wire logic        rx_stat_valid,  // status pulse
	input wire logic        rx_stat_pay_err // error bit
);
	// ----------------------------------------
	// frame end taken at the output
	// ----------------------------------------
	logic tk_last;
	assign tk_last = out_valid & out_ready & out_last;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	property p_hold;
		out_valid && !out_ready |=> out_valid && $stable(out_data);
	endproperty
	a_hold: assert property (p_hold)
		else $error("output byte moved while stalled");
	property p_gap; tk_last |=> !out_valid [*2]; endproperty
	a_gap: assert property (p_gap)
		else $error("output resumed inside the fold gap");
	property p_hdr;
		patch_valid && patch_offset == V4_HCS_OFS |-> $past(tk_last, 2);
	endproperty
	a_hdr: assert property (p_hdr)
		else $error("header patch mistimed");
	property p_pay;
		patch_valid && patch_offset != V4_HCS_OFS |-> $past(tk_last, 3);
	endproperty
	a_pay: assert property (p_pay)
		else $error("payload patch mistimed");
	property p_stat;
		rx_stat_valid |-> $past(tk_last, 3) && !patch_valid;
	endproperty
	a_stat: assert property (p_stat)
		else $error("status word mistimed");
	property p_pulse; rx_stat_valid |=> !rx_stat_valid; endproperty
	a_pulse: assert property (p_pulse)
		else $error("status pulse too long");
	property p_keep;
		!patch_valid |-> $stable(patch_offset) && $stable(patch_value);
	endproperty
	a_keep: assert property (p_keep)
		else $error("patch data moved without a pulse");
	property p_full; !in_ready |-> ##[0:2] out_valid; endproperty
	a_full: assert property (p_full)
		else $error("full fifo not offered");

	// main scenarios reached
	c_hdr: cover property (patch_valid && patch_offset == V4_HCS_OFS);
	c_pay: cover property (patch_valid && patch_offset != V4_HCS_OFS);
	c_err: cover property (rx_stat_valid && rx_stat_pay_err);
endmodule

bind cko_offload cko_props u_props (
	.clk_sys(clk_sys), .rst(rst), .in_ready(in_ready),
	.out_data(out_data), .out_valid(out_valid), .out_last(out_last),
	.out_ready(out_ready), .patch_valid(patch_valid),
	.patch_offset(patch_offset), .patch_value(patch_value),
	.rx_stat_valid(rx_stat_valid), .rx_stat_pay_err(rx_stat_pay_err)
);
`default_nettype wire

// *** sim/cko_sink.sv ***
// cko_sink: downstream buffer model, stores frames and applies patches
// assumes one frame in flight, frames under 256 bytes
`timescale 1ns/100ps
`default_nettype none
module cko_sink (
	input  wire logic        clk_sys,         // clock
	input  wire logic        rst,             // sync reset
	input  wire logic        slow,            // stall every other cycle
	input  wire logic  [7:0] out_data,        // byte in
	input  wire logic        out_valid,       // byte offered
	input  wire logic        out_last,        // frame end
	output logic             out_ready,       // byte taken
	input  wire logic        patch_valid,     // patch pulse
	input  wire logic [15:0] patch_offset,    // patch place
	input  wire logic [15:0] patch_value,     // patch word
	input  wire logic        rx_stat_valid,   // status pulse
	input  wire logic        rx_stat_checked, // transport checked
	input  wire logic        rx_stat_pay_err  // error bit
);
	logic [7:0]  mem_r[0:255];
	logic [15:0] cnt_r, len_r;
	int          frames_r, pcnt_r, scnt_r;
	logic        chk_r, err_r;

	// ----------------------------------------
	// capture bytes, patches and status
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			out_ready <= 1'b0;
			cnt_r <= 16'h0000;
			frames_r <= 0;
			pcnt_r <= 0;
			scnt_r <= 0;
		end else begin
			out_ready <= !slow || !out_ready;
			if (out_valid && out_ready) begin
				mem_r[cnt_r[7:0]] <= out_data;
				cnt_r <= out_last ? 16'h0000 : cnt_r + 16'h0001;
				if (out_last) begin
					len_r <= cnt_r + 16'h0001;
					frames_r <= frames_r + 1;
				end
			end
			if (patch_valid) begin
				mem_r[patch_offset[7:0]] <= patch_value[15:8];
				mem_r[8'(patch_offset + 16'h0001)] <= patch_value[7:0];
				pcnt_r <= pcnt_r + 1;
			end
			if (rx_stat_valid) begin
				scnt_r <= scnt_r + 1;
				chk_r <= rx_stat_checked;
				err_r <= rx_stat_pay_err;
			end
		end
	end
endmodule
`default_nettype wire

// *** sim/ip_checksum_offload_tb.sv ***
// ip_checksum_offload_tb: frame scenarios through the offload engine
// assumes cko_sink as downstream and the bound port checker
`timescale 1ns/100ps
`default_nettype none
module ip_checksum_offload_tb
	import cko_pkg::*;
;
	logic        clk_sys = 0, rst = 1, slow = 0, saw_full = 0;
	logic [7:0]  in_data = 0;
	logic        in_valid = 0, in_last = 0;
	logic        ctl_rx = 0, ctl_hdr_en = 0, ctl_pay_en = 0;
	logic        in_ready, out_valid, out_last, out_ready;
	logic        patch_valid, rx_stat_valid, rx_stat_checked, rx_stat_pay_err;
	logic [7:0]  out_data;
	logic [15:0] patch_offset, patch_value;
	logic [7:0]  fr[$], snd[$], exp[$];
	int          fails = 0, check_count = 0, cyc = 0, cso, np0, ns0, nf0;
	bit          iv4;

	cko_offload #(.FIFO_DEPTH(4)) dut (.clk_sys(clk_sys), .rst(rst),
		.in_data(in_data), .in_valid(in_valid), .in_last(in_last),
		.in_ready(in_ready), .ctl_rx(ctl_rx), .ctl_hdr_en(ctl_hdr_en),
		.ctl_pay_en(ctl_pay_en), .out_data(out_data),
		.out_valid(out_valid), .out_last(out_last), .out_ready(out_ready),
		.patch_valid(patch_valid), .patch_offset(patch_offset),
		.patch_value(patch_value), .rx_stat_valid(rx_stat_valid),
		.rx_stat_checked(rx_stat_checked), .rx_stat_pay_err(rx_stat_pay_err));
	cko_sink sink (.clk_sys(clk_sys), .rst(rst), .slow(slow),
		.out_data(out_data), .out_valid(out_valid), .out_last(out_last),
		.out_ready(out_ready), .patch_valid(patch_valid),
		.patch_offset(patch_offset), .patch_value(patch_value),
		.rx_stat_valid(rx_stat_valid), .rx_stat_checked(rx_stat_checked),
		.rx_stat_pay_err(rx_stat_pay_err));

	// clock, hang guard and fifo refusal watch, sampled off the edge
	always #4 clk_sys = ~clk_sys;
	always @(negedge clk_sys) begin
		cyc++;
		if (in_ready === 1'b0) saw_full = 1;
		if (cyc == 20000) begin
			fails++;
			results;
		end
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		check_count++;
		if (s !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic results;
		if (fails == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	function automatic logic [31:0] add(logic [31:0] a, int s, int e);
		for (int i = s; i < e; i += 2) a += {fr[i], (i + 1 < e) ? fr[i+1] : 8'h00};
		return a;
	endfunction
	function automatic logic [15:0] fin(logic [31:0] a);
		a = a[15:0] + a[31:16];
		a = a[15:0] + a[31:16];
		return ~a[15:0];
	endfunction
	// frame with correct sums, ext NH_NONE means no extension header
	task automatic build(bit v6, logic [7:0] ext, logic [7:0] pr, int pl);
		int tl, xl, ts;
		logic [15:0] n, c;
		logic [31:0] a;
		tl = ((pr == NH_TCP) ? 20 : 8) + pl;
		xl = (ext == NH_NONE) ? 0 : (ext == NH_FRAG) ? 8 : 16;
		iv4 = !v6;
		fr = {};
		repeat (12) fr.push_back(8'(fr.size() + 16));
		n = 16'(v6 ? xl + tl : 20 + tl);
		if (!v6) fr = {fr, 8'h08, 8'h00, 8'h45, 8'h00, n[15:8], n[7:0],
			8'h00, 8'h01, 8'h00, 8'h00, 8'h40, pr, 8'h00, 8'h00,
			8'hC0, 8'hA8, 8'h00, 8'h01, 8'hC0, 8'hA8, 8'h00, 8'h02};
		else begin
			fr = {fr, 8'h86, 8'hDD, 8'h60, 8'h00, 8'h00, 8'h00, n[15:8],
				n[7:0], (xl != 0) ? ext : pr, 8'h40};
			repeat (32) fr.push_back(8'(fr.size()));
		end
		if (xl != 0) fr = {fr, pr, 8'((ext == NH_AUTH) ? 2 : (xl - 8) / 8)};
		repeat ((xl != 0) ? xl - 2 : 0) fr.push_back(8'h00);
		ts = fr.size();
		repeat (tl) fr.push_back(8'(fr.size() * 3));
		cso = ts + ((pr == NH_TCP) ? CS_TCP : (pr == NH_UDP) ? CS_UDP : CS_ICMP);
		if (pr == NH_TCP) fr[ts+12] = 8'h50;
		if (pr == NH_UDP) fr[ts+4] = 8'(tl >> 8);
		if (pr == NH_UDP) fr[ts+5] = 8'(tl);
		fr[cso] = 8'h00;
		fr[cso+1] = 8'h00;
		c = fin(add(0, 14, 34));
		if (!v6) fr[24] = c[15:8];
		if (!v6) fr[25] = c[7:0];
		a = v6 ? add(pr + tl, 22, 54) :
			(pr == NH_ICMP) ? 0 : add(pr + tl, 26, 34);
		c = fin(add(a, ts, fr.size()));
		if (pr == NH_UDP && c == 16'h0000) c = 16'hFFFF;
		fr[cso] = c[15:8];
		fr[cso+1] = c[7:0];
	endtask
	// send frame, expect header/payload patch, optionally corrupt or cut
	task automatic xfer(bit rx, he, pe, hx, px, bad, int cut);
		bit hf, pf, ef;
		snd = fr;
		exp = fr;
		foreach (fr[i]) begin
			hf = iv4 && (i == 24 || i == 25);
			pf = i == cso || i == cso + 1;
			if (!rx && (hf || pf)) snd[i] = 8'h00;
			if (bad && i == cso) snd[i] = ~fr[i];
			exp[i] = ((hf && hx) || (pf && px)) ? fr[i] : snd[i];
		end
		repeat ((cut > 0) ? cut : 0) snd.pop_back();
		repeat ((cut > 0) ? cut : 0) exp.pop_back();
		// negative cut appends zero bytes past the ip end
		for (int i = 0; i < -cut; i++) begin
			snd.push_back(8'h00);
			exp.push_back(8'h00);
		end
		np0 = sink.pcnt_r;
		ns0 = sink.scnt_r;
		nf0 = sink.frames_r;
		@(negedge clk_sys);
		ctl_rx = rx;
		ctl_hdr_en = he;
		ctl_pay_en = pe;
		foreach (snd[i]) begin
			in_data = snd[i];
			in_valid = 1;
			in_last = i == snd.size() - 1;
			while (in_ready !== 1'b1) @(negedge clk_sys);
			@(negedge clk_sys);
		end
		in_valid = 0;
		while (sink.frames_r == nf0) @(negedge clk_sys);
		repeat (4) @(negedge clk_sys);
		chk("frame length", sink.len_r, exp.size());
		foreach (exp[i]) chk("frame byte", sink.mem_r[i], exp[i]);
		chk("patch count", sink.pcnt_r - np0, hx + px);
		chk("status count", sink.scnt_r - ns0, rx);
		if (rx) chk("checked", sink.chk_r, 1);
		ef = bad || cut > 0 || (cut < 0 && exp.size() > MIN_FRAME);
		if (rx) chk("payload error", sink.err_r, ef);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_v4_tx;
		logic [7:0] pv[3];
		pv = '{NH_TCP, NH_UDP, NH_ICMP};
		slow = 1;
		for (int k = 0; k < 3; k++) begin
			build(0, NH_NONE, pv[k], 20 + k);
			xfer(0, 1, 1, 1, 1, 0, 0);
		end
		slow = 0;
		chk("fifo refused", saw_full, 1);
		build(0, NH_NONE, NH_UDP, 11);
		xfer(0, 1, 0, 1, 0, 0, 0);
		xfer(0, 0, 1, 0, 1, 0, 0);
	endtask
	task automatic t_v6_tx;
		logic [7:0] xv[4], pv[4];
		xv = '{NH_HOPOPT, NH_ROUTE, NH_FRAG, NH_DSTOPT};
		pv = '{NH_TCP, NH_UDP, NH_ICMP6, NH_TCP};
		for (int k = 0; k < 4; k++) begin
			build(1, xv[k], pv[k], 9 + k);
			xfer(0, 1, 1, 0, 1, 0, 0);
		end
	endtask
	task automatic t_v6_ah_tx;
		build(1, NH_AUTH, NH_UDP, 9);
		xfer(0, 1, 1, 0, 0, 0, 0);
		xfer(0, 0, 0, 0, 0, 0, 0);
	endtask
	task automatic t_rx;
		build(0, NH_NONE, NH_TCP, 13);
		xfer(1, 1, 1, 0, 0, 0, 0);
		xfer(1, 0, 0, 0, 0, 1, 0);
		xfer(1, 0, 0, 0, 0, 0, 4);
		xfer(1, 0, 0, 0, 0, 0, -4);
		build(0, NH_NONE, NH_UDP, 4);
		xfer(1, 0, 0, 0, 0, 0, -14);
		build(1, NH_AUTH, NH_UDP, 8);
		xfer(1, 0, 0, 0, 0, 0, 0);
		build(1, NH_HOPOPT, NH_ICMP6, 12);
		xfer(1, 0, 0, 0, 0, 1, 0);
	endtask

	// main sequence
	initial begin
		repeat (6) @(negedge clk_sys);
		rst = 0;
		t_v4_tx;
		t_v6_tx;
		t_v6_ah_tx;
		t_rx;
		results;
	end
endmodule
`default_nettype wire
